// ---- cfg_por_dev.sv ----
// configuration memory device: power-on reset and restart control
`timescale 1ns/100ps
`include "cfg_por_regs.svh"
// Function
// RL1: hold reset until supply stable, count expired
// RL2: enable line held low extends reset
// RL3: delay 2 ms select high, 100 ms low
// RL4: host waits for reset end before scan
// RL5: supply low re-enters power-on reset
// RL6: fpga status low forces reset
// RL7: configuration error drives enable line low
// RL8: sample done sense at enable rise
// RL9: idle keeps clock and data static
// RL10: idle left only by power cycle
// RL11: board holds fpga config low until power good
// RL12: enable driven low during reset, released after
module cfg_por_dev #(
    parameter int unsigned SHORT_CYC = `POR_SHORT_CYC,
    parameter int unsigned LONG_CYC = `POR_LONG_CYC,
    parameter int unsigned DONE_TIMEOUT = `DONE_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // supply and strap
    input wire logic supply_low_i,
    input wire logic reset_delay_select_i,
    // configuration stream control
    input wire logic data_last_i,
    input wire logic data_bit_i,
    // status
    output logic por_done_o,
    output logic idle_mode_o,
    output logic config_active_o,
    // link
    cfg_link_if.dev link
);
    cfg_por_pkg::por_state_t state_q, state_d;
    logic [`POR_CNT_W-1:0] cnt_q, cnt_d;
    logic [`POR_CNT_W-1:0] limit;
    logic en_prev_q, en_prev_d;
    logic clk_q, clk_d;
    logic data_q, data_d;
    logic sent_q, sent_d;
    logic en_rise;

    // device holds the shared line low only while counting
    function automatic logic in_por(input cfg_por_pkg::por_state_t s);
        return (s == cfg_por_pkg::ST_POR);
    endfunction

    // locked idle: nothing but a power cycle may leave it
    function automatic logic in_idle(input cfg_por_pkg::por_state_t s);
        return (s == cfg_por_pkg::ST_IDLE);
    endfunction

    // delay select is read live, so a strap change mid-count takes effect at once
    always_comb
    begin
        if (reset_delay_select_i)
            limit = `POR_CNT_W'(SHORT_CYC); // RL3
        else
            limit = `POR_CNT_W'(LONG_CYC); // RL3
    end

    // one-cycle rise pulse; only looked at while waiting in hold
    assign en_rise = link.enable_line & ~en_prev_q; // RL8

    // reset value matches the line driven low in reset, so no false rise follows it
    always_comb
    begin
        en_prev_d = link.enable_line;
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            en_prev_q <= 1'b0;
        else
            en_prev_q <= en_prev_d;
    end

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        sent_d = sent_q;
        unique case (state_q)
            cfg_por_pkg::ST_POR:
            begin
                // counter restarts while supply is still ramping
                if (supply_low_i)
                    cnt_d = '0;
                else if (cnt_q >= limit - `POR_CNT_W'(1))
                    state_d = cfg_por_pkg::ST_HOLD; // RL1
                else
                    cnt_d = cnt_q + `POR_CNT_W'(1);
            end
            cfg_por_pkg::ST_HOLD:
            begin
                // released; waiting while others hold the line low
                if (en_rise)
                begin
                    cnt_d = '0;
                    sent_d = 1'b0;
                    if (link.done_sense_input)
                        state_d = cfg_por_pkg::ST_IDLE; // RL8
                    else
                        state_d = cfg_por_pkg::ST_CONFIG;
                end
            end
            cfg_por_pkg::ST_CONFIG:
            begin
                // timeout only runs once the last bit is out
                if (data_last_i)
                    sent_d = 1'b1;
                if (sent_q)
                    cnt_d = cnt_q + `POR_CNT_W'(1);
                if (link.done_sense_input)
                    state_d = cfg_por_pkg::ST_USER;
                else if (sent_q && cnt_q >= `POR_CNT_W'(DONE_TIMEOUT))
                begin
                    cnt_d = '0;
                    state_d = cfg_por_pkg::ST_POR; // RL7
                end
            end
            cfg_por_pkg::ST_USER:
            begin
            end
            cfg_por_pkg::ST_IDLE:
            begin
                // no exit: only resetn_i (a power cycle) leaves idle
            end
            default:
                state_d = cfg_por_pkg::ST_POR;
        endcase
        // supply loss and fpga status low win over all but idle
        if (!in_idle(state_q)) // RL10
        begin
            if (supply_low_i) // RL5
            begin
                state_d = cfg_por_pkg::ST_POR;
                cnt_d = '0;
            end
            else if (!link.target_status_low) // RL6
            begin
                // a reset request: drive the line and recount, else nothing restarts
                state_d = cfg_por_pkg::ST_POR;
                cnt_d = '0;
            end
            else if (!link.enable_line && state_q != cfg_por_pkg::ST_POR
                     && state_q != cfg_por_pkg::ST_HOLD) // RL2
            begin
                state_d = cfg_por_pkg::ST_HOLD;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q <= cfg_por_pkg::ST_POR; // RL5
            cnt_q <= '0;
            sent_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sent_q <= sent_d;
        end
    end

    // stream pins park at low clock, high data the moment configuring ends
    always_comb
    begin
        clk_d = 1'b0; // RL9
        data_d = 1'b1; // RL9
        if (state_q == cfg_por_pkg::ST_CONFIG && state_d == cfg_por_pkg::ST_CONFIG)
        begin
            clk_d = ~clk_q;
            data_d = data_bit_i;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            clk_q <= 1'b0;
            data_q <= 1'b1;
        end
        else
        begin
            clk_q <= clk_d;
            data_q <= data_d;
        end
    end

    assign link.enable_dev_oe = in_por(state_q); // RL12
    assign link.status_dev_oe = 1'b0;
    assign link.config_clock_out = clk_q;
    assign link.config_data = data_q;
    assign por_done_o = !in_por(state_q); // RL4
    assign idle_mode_o = in_idle(state_q);
    assign config_active_o = (state_q == cfg_por_pkg::ST_CONFIG);
endmodule

// ---- cfg_por_regs.svh ----
// timing constants for the power-on reset and restart control
`ifndef CFG_POR_REGS_SVH
`define CFG_POR_REGS_SVH
`define CLK_PERIOD_NS 50
`define POR_SHORT_MS 2
`define POR_LONG_MS 100
`define POR_SHORT_CYC ((`POR_SHORT_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_LONG_CYC ((`POR_LONG_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DONE_TIMEOUT_CYC 1024
`define POR_CNT_W 32
`endif

// ---- cfg_por_pkg.sv ----
// state type of the device end of the reset and restart link
package cfg_por_pkg;
    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_HOLD = 3'b001,
        ST_CONFIG = 3'b010,
        ST_USER = 3'b011,
        ST_IDLE = 3'b100
    } por_state_t;
endpackage

// ---- cfg_link_if.sv ----
// link between configuration memory device and target fpga
`timescale 1ns/100ps
interface cfg_link_if;
    logic enable_dev_oe;
    logic enable_fpga_oe;
    logic enable_line;
    logic status_dev_oe;
    logic status_fpga_oe;
    logic target_status_low;
    logic done_sense_input;
    logic config_clock_out;
    logic config_data;
    // open-drain wires: low while any party drives, pulled up otherwise
    assign enable_line = ~(enable_dev_oe | enable_fpga_oe);
    assign target_status_low = ~(status_dev_oe | status_fpga_oe);
    modport dev (
        output enable_dev_oe,
        output status_dev_oe,
        output config_clock_out,
        output config_data,
        input enable_line,
        input target_status_low,
        input done_sense_input
    );
    modport fpga (
        output enable_fpga_oe,
        output status_fpga_oe,
        output done_sense_input,
        input enable_line,
        input target_status_low,
        input config_clock_out,
        input config_data
    );
endinterface

// ---- cfg_por_fpga.sv ----
// fpga end: power-good hold, reconfiguration request and done sense
`timescale 1ns/100ps
module cfg_por_fpga (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // user side
    input wire logic power_good_i,
    input wire logic reconfig_req_i,
    input wire logic config_done_i,
    output logic clock_seen_o,
    // link
    cfg_link_if.fpga link
);
    logic seen_q, seen_d;

    always_comb
    begin
        seen_d = seen_q | link.config_clock_out;
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            seen_q <= 1'b0;
        else
            seen_q <= seen_d;
    end

    // power-good low holds the enable line low until supplies settle
    assign link.enable_fpga_oe = ~power_good_i; // RL11 RL2
    assign link.status_fpga_oe = reconfig_req_i; // RL6
    assign link.done_sense_input = config_done_i & power_good_i;
    assign clock_seen_o = seen_q;
endmodule

// ---- cfg_link_props.sv ----
// assertions on the reset and restart link
`timescale 1ns/100ps
module cfg_link_props #(
    parameter int SHORT = 8
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic enable_dev_oe,
    input wire logic enable_fpga_oe,
    input wire logic enable_line,
    input wire logic status_dev_oe,
    input wire logic status_fpga_oe,
    input wire logic done_sense_input,
    input wire logic config_clock_out
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    sequence rise_done_s;
        $rose(enable_line) ##0 done_sense_input;
    endsequence
    sequence rise_cfg_s;
        $rose(enable_line) && !done_sense_input ##1 (enable_line && !done_sense_input)[*3];
    endsequence
    reset_drive_a: assert property ($rose(resetn_i) |-> enable_dev_oe)
        else $error("enable not driven at reset release");
    release_min_a: assert property ($fell(enable_dev_oe) |-> $past(enable_dev_oe, SHORT))
        else $error("enable released before count ran out");
    status_quiet_a: assert property (status_fpga_oe |=> !config_clock_out && !status_dev_oe)
        else $error("config clock ran or status driven while status held low");
    clock_quiet_a: assert property ((!enable_line)[*3] |-> !config_clock_out)
        else $error("config clock high while enable held low");
    idle_static_a: assert property (rise_done_s |=> (!config_clock_out)[*8])
        else $error("config clock moved after done seen");
    cfg_start_a: assert property (rise_cfg_s |-> ##[0:3] config_clock_out)
        else $error("configuration did not start");
    status_stop_a: assert property ($rose(status_fpga_oe) |-> ##[1:3] (!config_clock_out)[*2])
        else $error("config clock ran on after status low");
    clock_pulse_a: assert property (config_clock_out |=> !config_clock_out)
        else $error("config clock high for two cycles");
endmodule

// ---- config_por_and_restart_control_bench.sv ----
// bench for the power-on reset and restart link
`timescale 1ns/100ps
module config_por_and_restart_control_bench;
    logic mclk_i = 0, resetn_i = 0, supply_low_i = 0, reset_delay_select_i = 1;
    logic data_last_i = 0, data_bit_i = 1, power_good_i = 1, reconfig_req_i = 0;
    logic config_done_i = 0, por_done_o, idle_mode_o, config_active_o, clock_seen_o;
    int n_fail = 0, n_tests = 0, c;
    cfg_link_if cfg_link_if_inst();
    cfg_por_dev #(.SHORT_CYC(8), .LONG_CYC(20), .DONE_TIMEOUT(16)) cfg_por_dev_inst (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .supply_low_i(supply_low_i),
        .reset_delay_select_i(reset_delay_select_i), .data_last_i(data_last_i),
        .data_bit_i(data_bit_i), .por_done_o(por_done_o), .idle_mode_o(idle_mode_o),
        .config_active_o(config_active_o), .link(cfg_link_if_inst.dev));
    cfg_por_fpga cfg_por_fpga_inst (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .power_good_i(power_good_i),
        .reconfig_req_i(reconfig_req_i), .config_done_i(config_done_i),
        .clock_seen_o(clock_seen_o), .link(cfg_link_if_inst.fpga));
    cfg_link_props #(.SHORT(8)) cfg_link_props_inst (
        .mclk_i(mclk_i), .resetn_i(resetn_i),
        .enable_dev_oe(cfg_link_if_inst.enable_dev_oe),
        .enable_fpga_oe(cfg_link_if_inst.enable_fpga_oe),
        .enable_line(cfg_link_if_inst.enable_line),
        .status_dev_oe(cfg_link_if_inst.status_dev_oe),
        .status_fpga_oe(cfg_link_if_inst.status_fpga_oe),
        .done_sense_input(cfg_link_if_inst.done_sense_input),
        .config_clock_out(cfg_link_if_inst.config_clock_out));
    initial
    begin
        forever #25 mclk_i = ~mclk_i;
    end
    task end_sim();
        $display("%0d checks, %0d mismatches", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // cycles from the end of a power-good hold of h after reset release until enable rises
    task por(input logic s, input int h, output int n);
        resetn_i = 0;
        reset_delay_select_i = s;
        step(6);
        resetn_i = 1;
        step(h);
        power_good_i = 1;
        n = 0;
        while (cfg_link_if_inst.enable_line !== 1'b1 && n < 200)
        begin
            step(1);
            n++;
        end
        if (n == 200)
        begin
            n_fail++;
            end_sim();
        end
    endtask
    initial
    begin
        por(1'b1, 0, c);
        chk(32'h1, c inside {[8:9]});
        chk(32'h1, por_done_o);
        step(4);
        chk(32'h1, config_active_o);
        chk(32'h1, clock_seen_o);
        data_bit_i = 0;
        data_last_i = 1;
        step(1);
        chk(32'h0, cfg_link_if_inst.config_data);
        data_bit_i = 1;
        data_last_i = 0;
        step(19);
        chk(32'h0, cfg_link_if_inst.enable_line);
        $display("short delay and config error done");
        supply_low_i = 1;
        step(3);
        chk(32'h0, cfg_link_if_inst.enable_line);
        chk(32'h0, por_done_o);
        supply_low_i = 0;
        por(1'b1, 0, c);
        step(4);
        reconfig_req_i = 1;
        step(3);
        chk(32'h0, cfg_link_if_inst.target_status_low);
        chk(32'h0, config_active_o);
        chk(32'h0, cfg_link_if_inst.enable_line);
        reconfig_req_i = 0;
        step(10);
        chk(32'h1, config_active_o);
        $display("supply loss and status request done");
        por(1'b0, 0, c);
        chk(32'h1, c inside {[20:21]});
        power_good_i = 0;
        por(1'b1, 30, c);
        chk(32'h1, c inside {[0:9]});
        $display("long delay and power-good hold done");
        config_done_i = 1;
        por(1'b1, 0, c);
        step(3);
        chk(32'h1, idle_mode_o);
        supply_low_i = 1;
        reconfig_req_i = 1;
        step(10);
        chk(32'h1, idle_mode_o);
        chk(32'h0, cfg_link_if_inst.config_clock_out);
        chk(32'h1, cfg_link_if_inst.config_data);
        supply_low_i = 0;
        reconfig_req_i = 0;
        config_done_i = 0;
        por(1'b1, 0, c);
        step(4);
        chk(32'h0, idle_mode_o);
        $display("idle mode done");
        end_sim();
    end
endmodule
